// File: dsd_pkg.sv
// constants for the divide-step and double-precision mac datapath
// shared by the datapath top and its mac unit
package dsd_pkg;

    // data widths
    localparam int ACC_W  = 56;
    localparam int WORD_W = 24;
    localparam int ADDR_W = 4;

    // accumulator field positions
    localparam int ACC_MSB      = 55;
    localparam int ACC_MID_LO   = 24;
    localparam int ACC_EXT_LO   = 48;
    localparam int WORD_MSB     = 23;
    localparam int MAC_SHIFT    = 24;

    // condition_code_flags bit positions
    localparam int CCF_S = 7;
    localparam int CCF_L = 6;
    localparam int CCF_E = 5;
    localparam int CCF_U = 4;
    localparam int CCF_N = 3;
    localparam int CCF_Z = 2;
    localparam int CCF_V = 1;
    localparam int CCF_C = 0;
    localparam logic [7:0] CCF_RESET = 8'h00;

    // register map, word addresses on the plain register port
    localparam logic [ADDR_W-1:0] REG_CCF   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_X_LO  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_X_HI  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_Y_LO  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_Y_HI  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_A_LOW = 4'h5;
    localparam logic [ADDR_W-1:0] REG_A_MID = 4'h6;
    localparam logic [ADDR_W-1:0] REG_A_EXT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_B_LOW = 4'h8;
    localparam logic [ADDR_W-1:0] REG_B_MID = 4'h9;
    localparam logic [ADDR_W-1:0] REG_B_EXT = 4'hA;
    localparam logic [23:0] UNMAPPED_RD = 24'h000000;

    // operand interpretation of the mac
    typedef enum logic [1:0] {
        DSD_MAC_SS = 2'b00,
        DSD_MAC_SU = 2'b01,
        DSD_MAC_UU = 2'b11
    } dsd_mac_mode_t;

    // datapath sequence states, gray along idle -> exec -> done
    typedef enum logic [1:0] {
        DSD_ST_IDLE = 2'b00,
        DSD_ST_EXEC = 2'b01,
        DSD_ST_DONE = 2'b11
    } dsd_state_t;

endpackage

// File: dsd_div_step.sv
// one nonrestoring fractional divide iteration, purely combinational
// assumes the caller registers the accumulator and flags
`timescale 1ns/100ps
module dsd_div_step #(
    parameter int ACC_W  = 56,
    parameter int WORD_W = 24
) (
    // operands
    input  wire logic [ACC_W-1:0]  acc_in,
    input  wire logic [WORD_W-1:0] divisor,
    input  wire logic              carry_in,
    // results
    output logic      [ACC_W-1:0]  acc_out,
    output logic                   ovf_out,
    output logic                   carry_out
);
    localparam int UP_W = ACC_W - WORD_W;

    logic              signs_differ;
    logic [ACC_W-1:0]  shifted;
    logic [UP_W-1:0]   divisor_ext;
    logic [UP_W-1:0]   upper;

    if (ACC_W != 56 || WORD_W != 24) begin : g_bad_width
        $error("dsd_div_step: widths fixed at 56/24");
    end

    always_comb begin
        signs_differ = acc_in[ACC_W-1] ^ divisor[WORD_W-1];
        shifted      = {acc_in[ACC_W-2:0], carry_in};
        divisor_ext  = {{(UP_W-WORD_W){divisor[WORD_W-1]}}, divisor};
        if (signs_differ) begin
            upper = shifted[ACC_W-1:WORD_W] + divisor_ext;
        end else begin
            upper = shifted[ACC_W-1:WORD_W] - divisor_ext;
        end
        acc_out   = {upper, shifted[WORD_W-1:0]};
        ovf_out   = acc_in[ACC_W-1] ^ acc_in[ACC_W-2];
        carry_out = ~upper[UP_W-1];
    end
endmodule

// File: dsd_double_precision_mac_unit.sv
// double-precision multiply-accumulate with 24-bit right shift, combinational
// assumes the caller registers the accumulator and flags
`timescale 1ns/100ps
module dsd_double_precision_mac_unit #(
    parameter int ACC_W  = 56,
    parameter int WORD_W = 24
) (
    // operands
    input  wire logic [ACC_W-1:0]  acc_in,
    input  wire logic [WORD_W-1:0] src1,
    input  wire logic [WORD_W-1:0] src2,
    input  wire logic [1:0]        mode,
    input  wire logic              negate,
    // results
    output logic      [ACC_W-1:0]  acc_out,
    output logic                   ovf_out
);
    localparam int PR_W = 2 * WORD_W + 2;

    logic signed [WORD_W:0]   op1;
    logic signed [WORD_W:0]   op2;
    logic signed [PR_W-1:0]   prod;
    logic        [ACC_W-1:0]  prod_ext;
    logic        [ACC_W-1:0]  addend;
    logic        [ACC_W-1:0]  shifted;

    if (ACC_W <= PR_W) begin : g_narrow_acc
        $error("dsd_double_precision_mac_unit: accumulator too narrow for product");
    end

    always_comb begin
        // unsigned operands get a zero 25th sign bit so one signed multiplier serves all
        op1 = (mode == dsd_pkg::DSD_MAC_UU) ? {1'b0, src1}
                                            : {src1[WORD_W-1], src1};
        op2 = (mode == dsd_pkg::DSD_MAC_SS) ? {src2[WORD_W-1], src2}
                                            : {1'b0, src2};
        prod     = op1 * op2;
        prod_ext = {{(ACC_W-PR_W){prod[PR_W-1]}}, prod};
        addend   = negate ? (~prod_ext + 56'h1) : prod_ext;
        shifted  = {{dsd_pkg::MAC_SHIFT{acc_in[ACC_W-1]}},
                    acc_in[ACC_W-1:dsd_pkg::MAC_SHIFT]};
        acc_out  = shifted + addend;
        ovf_out  = (shifted[ACC_W-1] == addend[ACC_W-1])
                   && (acc_out[ACC_W-1] != shifted[ACC_W-1]);
    end
endmodule

// File: dsd_datapath.sv
// divide-step and double-precision mac datapath slice with its register file
// assumes one operation request per cycle from the decoder on the same clock
// one clock, synchronous active-low reset, no wait states on the register port
// operands out of range are not detected; results are then meaningless
//
// Operation
// - divide starts with xor of accumulator bit 55 and divisor bit 23
// - divide shifts accumulator left one, carry enters bit 0
// - signs differ: add divisor to middle word after shift
// - signs equal: subtract divisor from middle word after shift
// - divisor sign-extended so carry out is next quotient bit
// - quotient builds in low word, partial remainder above it
// - divide sets overflow if accumulator msb changed by shift
// - divide sets limit whenever it sets overflow
// - divide sets carry when result bit 55 is zero
// - divide keeps scaling, extension, unnormalized, negative, zero flags
// - divide divisor from four input registers, destination from two accumulators
// - mac shifts accumulator right 24 then adds or subtracts product
// - mac supports signed-signed, signed-unsigned and unsigned-unsigned
// - negative option negates product, positive is default
// - mac takes any input register pair and either accumulator
// - mac updates L E U N Z V, keeps S and C
`timescale 1ns/100ps
module dsd_datapath #(
    parameter int ACC_W  = 56,
    parameter int WORD_W = 24,
    parameter int ADDR_W = 4
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [WORD_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [WORD_W-1:0] reg_rdata,
    // operation request
    input  wire logic              op_valid,
    input  wire logic              op_is_div,
    input  wire logic              op_dest_sel,
    input  wire logic [1:0]        divisor_select_field,
    input  wire logic [3:0]        mac_source_pair_field,
    input  wire logic [1:0]        op_mac_mode,
    input  wire logic              op_mac_negate,
    // status
    output logic                   op_done,
    output logic [7:0]             condition_code_flags,
    output logic [ACC_W-1:0]       first_acc,
    output logic [ACC_W-1:0]       second_acc
);
    localparam int NREG = 4;

    // register file
    logic [WORD_W-1:0] in_reg_r [NREG];
    logic [ACC_W-1:0]  acc_r    [2];
    // flag register
    logic [7:0]        ccf_r;
    logic [7:0]        ccf_nxt;
    logic [WORD_W-1:0] rdata_r;
    // arithmetic operands and results
    logic [ACC_W-1:0]  acc_sel;
    logic [ACC_W-1:0]  div_acc;
    logic              div_ovf;
    logic              div_carry;
    logic [ACC_W-1:0]  mac_acc;
    logic              mac_ovf;
    logic              mac_ext;
    logic              mac_unnorm;
    logic              mac_neg;
    logic              mac_zero;
    logic [ACC_W-1:0]  op_result;
    logic [WORD_W-1:0] divisor;
    logic [WORD_W-1:0] mac_src1;
    logic [WORD_W-1:0] mac_src2;
    // write decode
    logic [1:0]        wr_idx;
    logic              wr_is_in;
    logic              wr_acc_sel;
    logic [1:0]        wr_acc_part;
    // sequence state
    dsd_pkg::dsd_state_t state_r;

    // the map and both arithmetic units are built for the package widths only
    if (ACC_W != dsd_pkg::ACC_W) begin : g_bad_acc_w
        $error("dsd_datapath: ACC_W must match the package");
    end
    if (WORD_W != dsd_pkg::WORD_W) begin : g_bad_word_w
        $error("dsd_datapath: WORD_W must match the package");
    end
    if (ADDR_W != dsd_pkg::ADDR_W) begin : g_bad_addr_w
        $error("dsd_datapath: ADDR_W must match the package");
    end

    // operand selection
    // read straight from the registers, so a back-to-back op sees the last result
    always_comb begin
        acc_sel  = acc_r[op_dest_sel];
        divisor  = in_reg_r[divisor_select_field];
        mac_src1 = in_reg_r[mac_source_pair_field[3:2]];
        mac_src2 = in_reg_r[mac_source_pair_field[1:0]];
    end

    // the carry flag feeds the next quotient bit straight back
    // overflow is judged on the accumulator before its shift
    dsd_div_step #(
        .ACC_W  (ACC_W),
        .WORD_W (WORD_W)
    ) u_div (
        .acc_in    (acc_sel),
        .divisor   (divisor),
        .carry_in  (ccf_r[dsd_pkg::CCF_C]),
        .acc_out   (div_acc),
        .ovf_out   (div_ovf),
        .carry_out (div_carry)
    );

    // one signed multiplier serves all three operand modes
    dsd_double_precision_mac_unit #(
        .ACC_W  (ACC_W),
        .WORD_W (WORD_W)
    ) u_mac (
        .acc_in  (acc_sel),
        .src1    (mac_src1),
        .src2    (mac_src2),
        .mode    (op_mac_mode),
        .negate  (op_mac_negate),
        .acc_out (mac_acc),
        .ovf_out (mac_ovf)
    );

    assign op_result = op_is_div ? div_acc : mac_acc;

    // standard flags of the mac result; no limiting, the sum is stored as it stands
    always_comb begin
        // extension: bits 55:47 disagree, the value has left the 48-bit window
        mac_ext    = ~((&mac_acc[ACC_W-1:dsd_pkg::ACC_EXT_LO-1])
                       | ~(|mac_acc[ACC_W-1:dsd_pkg::ACC_EXT_LO-1]));
        // unnormalized: the two bits below the extension agree
        mac_unnorm = ~(mac_acc[dsd_pkg::ACC_EXT_LO-1]
                       ^ mac_acc[dsd_pkg::ACC_EXT_LO-2]);
        // negative and zero follow the full 56-bit result
        mac_neg    = mac_acc[ACC_W-1];
        mac_zero   = (mac_acc == '0);
    end

    // flag update for the requested operation
    always_comb begin
        ccf_nxt = ccf_r;
        if (op_valid && op_is_div) begin
            // scaling, extension, unnormalized, negative, zero kept as they were
            // limit is sticky: only reset or a software write clears it
            ccf_nxt[dsd_pkg::CCF_V] = div_ovf;
            ccf_nxt[dsd_pkg::CCF_L] = ccf_r[dsd_pkg::CCF_L] | div_ovf;
            ccf_nxt[dsd_pkg::CCF_C] = div_carry;
        end else if (op_valid) begin
            // scaling and carry kept as they were
            ccf_nxt[dsd_pkg::CCF_V] = mac_ovf;
            ccf_nxt[dsd_pkg::CCF_L] = ccf_r[dsd_pkg::CCF_L] | mac_ovf;
            ccf_nxt[dsd_pkg::CCF_E] = mac_ext;
            ccf_nxt[dsd_pkg::CCF_U] = mac_unnorm;
            ccf_nxt[dsd_pkg::CCF_N] = mac_neg;
            ccf_nxt[dsd_pkg::CCF_Z] = mac_zero;
        end else if (reg_wr && reg_addr == dsd_pkg::REG_CCF) begin
            // a software write to the flags loses to an operation in the same cycle
            ccf_nxt = reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ccf_r <= dsd_pkg::CCF_RESET;
        end else begin
            ccf_r <= ccf_nxt;
        end
    end

    // register write decode
    // unmapped addresses decode to no target and are ignored
    always_comb begin
        wr_is_in    = 1'b0;
        wr_idx      = 2'd0;
        wr_acc_sel  = 1'b0;
        wr_acc_part = 2'd3;
        case (reg_addr)
            dsd_pkg::REG_X_LO: begin
                wr_is_in = 1'b1;
                wr_idx   = 2'd0;
            end
            dsd_pkg::REG_X_HI: begin
                wr_is_in = 1'b1;
                wr_idx   = 2'd1;
            end
            dsd_pkg::REG_Y_LO: begin
                wr_is_in = 1'b1;
                wr_idx   = 2'd2;
            end
            dsd_pkg::REG_Y_HI: begin
                wr_is_in = 1'b1;
                wr_idx   = 2'd3;
            end
            dsd_pkg::REG_A_LOW: wr_acc_part = 2'd0;
            dsd_pkg::REG_A_MID: wr_acc_part = 2'd1;
            dsd_pkg::REG_A_EXT: wr_acc_part = 2'd2;
            dsd_pkg::REG_B_LOW: begin
                wr_acc_sel  = 1'b1;
                wr_acc_part = 2'd0;
            end
            dsd_pkg::REG_B_MID: begin
                wr_acc_sel  = 1'b1;
                wr_acc_part = 2'd1;
            end
            dsd_pkg::REG_B_EXT: begin
                wr_acc_sel  = 1'b1;
                wr_acc_part = 2'd2;
            end
            default: wr_acc_part = 2'd3;
        endcase
    end

    // input registers, one per entry, never touched by an operation
    generate
        for (genvar r = 0; r < NREG; r++) begin : g_in
            // a software write beside an operation is dropped, never queued
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    in_reg_r[r] <= '0;
                end else if (reg_wr && wr_is_in && !op_valid && wr_idx == 2'(r)) begin
                    in_reg_r[r] <= reg_wdata;
                end
            end
        end
    endgenerate

    // the extension word keeps only its low byte; its upper bits read back as zero
    // accumulators; an operation in the same cycle wins over a software write
    generate
        for (genvar g = 0; g < 2; g++) begin : g_acc
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    acc_r[g] <= '0;
                end else if (op_valid && op_dest_sel == 1'(g)) begin
                    acc_r[g] <= op_result;
                end else if (reg_wr && !op_valid && wr_acc_sel == 1'(g)) begin
                    case (wr_acc_part)
                        2'd0: acc_r[g][WORD_W-1:0] <= reg_wdata;
                        2'd1: acc_r[g][dsd_pkg::ACC_EXT_LO-1:dsd_pkg::ACC_MID_LO] <= reg_wdata;
                        2'd2: acc_r[g][ACC_W-1:dsd_pkg::ACC_EXT_LO] <= reg_wdata[7:0];
                        default: acc_r[g] <= acc_r[g];
                    endcase
                end
            end
        end
    endgenerate

    // read port, data stands one cycle after the strobe
    // zero outside the answer cycle, so reads can be or-ed onto a shared bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                dsd_pkg::REG_CCF:   rdata_r <= {16'h0000, ccf_r};
                dsd_pkg::REG_X_LO:  rdata_r <= in_reg_r[0];
                dsd_pkg::REG_X_HI:  rdata_r <= in_reg_r[1];
                dsd_pkg::REG_Y_LO:  rdata_r <= in_reg_r[2];
                dsd_pkg::REG_Y_HI:  rdata_r <= in_reg_r[3];
                dsd_pkg::REG_A_LOW: rdata_r <= acc_r[0][WORD_W-1:0];
                dsd_pkg::REG_A_MID: rdata_r <= acc_r[0][dsd_pkg::ACC_EXT_LO-1:dsd_pkg::ACC_MID_LO];
                dsd_pkg::REG_A_EXT: rdata_r <= {16'h0000, acc_r[0][ACC_W-1:dsd_pkg::ACC_EXT_LO]};
                dsd_pkg::REG_B_LOW: rdata_r <= acc_r[1][WORD_W-1:0];
                dsd_pkg::REG_B_MID: rdata_r <= acc_r[1][dsd_pkg::ACC_EXT_LO-1:dsd_pkg::ACC_MID_LO];
                dsd_pkg::REG_B_EXT: rdata_r <= {16'h0000, acc_r[1][ACC_W-1:dsd_pkg::ACC_EXT_LO]};
                default:            rdata_r <= dsd_pkg::UNMAPPED_RD;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    // sequence tracking: every operation finishes in one cycle
    // exec is entered only at an edge that took a request, so it doubles as the done pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= dsd_pkg::DSD_ST_IDLE;
        end else begin
            case (state_r)
                dsd_pkg::DSD_ST_IDLE: state_r <= op_valid ? dsd_pkg::DSD_ST_EXEC
                                                          : dsd_pkg::DSD_ST_IDLE;
                dsd_pkg::DSD_ST_EXEC: state_r <= op_valid ? dsd_pkg::DSD_ST_EXEC
                                                          : dsd_pkg::DSD_ST_DONE;
                dsd_pkg::DSD_ST_DONE: state_r <= op_valid ? dsd_pkg::DSD_ST_EXEC
                                                          : dsd_pkg::DSD_ST_IDLE;
                default:              state_r <= dsd_pkg::DSD_ST_IDLE;
            endcase
        end
    end

    assign reg_rdata            = rdata_r;
    assign op_done              = (state_r == dsd_pkg::DSD_ST_EXEC);
    assign condition_code_flags = ccf_r;
    assign first_acc            = acc_r[0];
    assign second_acc           = acc_r[1];
endmodule

// File: dsd_datapath_monitor.sv
// port-level assertions for the divide-step and dp mac datapath
// assumes bind into dsd_datapath, single clock, synchronous active-low reset
`timescale 1ns/100ps
module dsd_datapath_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // requests
    input wire logic        reg_rd,
    input wire logic        op_valid,
    input wire logic        op_is_div,
    input wire logic        op_dest_sel,
    input wire logic        op_mac_negate,
    input wire logic [1:0]  op_mac_mode,
    // results
    input wire logic [23:0] reg_rdata,
    input wire logic        op_done,
    input wire logic [7:0]  condition_code_flags,
    input wire logic [55:0] first_acc,
    input wire logic [55:0] second_acc
);
    wire logic        div_go = op_valid && op_is_div && rst_n;
    wire logic        mac_go = op_valid && !op_is_div && rst_n;
    wire logic [7:0]  f      = condition_code_flags;
    wire logic [55:0] dacc   = op_dest_sel ? second_acc : first_acc;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_done;
        $past(rst_n) |-> op_done == $past(op_valid);
    endproperty
    a_done: assert property (p_done) else $error("op_done not one cycle after request");
    property p_shift;
        $past(div_go) |-> ($past(op_dest_sel) ? second_acc[23:0] : first_acc[23:0])
            == {$past(dacc[22:0]), $past(f[0])};
    endproperty
    a_shift: assert property (p_shift) else $error("divide low word shift wrong");
    property p_carry;
        $past(div_go) |-> f[0] == !($past(op_dest_sel) ? second_acc[55] : first_acc[55]);
    endproperty
    a_carry: assert property (p_carry) else $error("divide carry wrong");
    property p_ovf;
        $past(div_go) |-> f[1] == $past(dacc[55] ^ dacc[54]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("divide overflow wrong");
    property p_lim;
        $past(div_go) && f[1] |-> f[6];
    endproperty
    a_lim: assert property (p_lim) else $error("divide limit not set");
    property p_dkeep;
        $past(div_go) |-> {f[7], f[5:2]} == $past({f[7], f[5:2]});
    endproperty
    a_dkeep: assert property (p_dkeep) else $error("divide touched kept flags");
    property p_mkeep;
        $past(mac_go) |-> {f[7], f[0]} == $past({f[7], f[0]});
    endproperty
    a_mkeep: assert property (p_mkeep) else $error("mac touched kept flags");
    property p_mnz;
        $past(mac_go) |-> f[3] == ($past(op_dest_sel) ? second_acc[55] : first_acc[55])
            && f[2] == (($past(op_dest_sel) ? second_acc : first_acc) == 56'h0);
    endproperty
    a_mnz: assert property (p_mnz) else $error("mac negative or zero flag wrong");
    property p_other;
        $past(op_valid && rst_n) |-> ($past(op_dest_sel) ? $stable(first_acc)
            : $stable(second_acc));
    endproperty
    a_other: assert property (p_other) else $error("unselected accumulator changed");
    property p_rdz;
        !$past(reg_rd && rst_n) |-> reg_rdata == 24'h000000;
    endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside its cycle");

    c_div: cover property (div_go ##1 div_go);
    c_neg: cover property (mac_go && op_mac_negate);
    c_uu:  cover property (mac_go && op_mac_mode == 2'b11);
endmodule

bind dsd_datapath dsd_datapath_monitor dsd_datapath_monitor_i (.clk(clk), .rst_n(rst_n),
    .reg_rd(reg_rd), .op_valid(op_valid), .op_is_div(op_is_div), .op_dest_sel(op_dest_sel),
    .op_mac_negate(op_mac_negate), .op_mac_mode(op_mac_mode), .reg_rdata(reg_rdata),
    .op_done(op_done), .condition_code_flags(condition_code_flags),
    .first_acc(first_acc), .second_acc(second_acc));

// File: dsd_datapath_test.sv
// self-checking bench for the datapath, reference model kept in the bench
// assumes the register map and flag positions of dsd_pkg
`timescale 1ns/100ps
module dsd_datapath_test;
    logic        clk, rst_n, reg_wr, reg_rd, op_valid, op_is_div, op_dest_sel, op_mac_negate;
    logic [3:0]  reg_addr, mac_source_pair_field;
    logic [23:0] reg_wdata, reg_rdata;
    logic [1:0]  divisor_select_field, op_mac_mode;
    logic        op_done;
    logic [7:0]  condition_code_flags, f_m;
    logic [55:0] first_acc, second_acc;
    logic [55:0] acc_m [2];
    logic [23:0] xr [4];
    int          err_count, n_tests;

    dsd_datapath dsd_datapath_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .op_valid, .op_is_div, .op_dest_sel, .divisor_select_field,
        .mac_source_pair_field, .op_mac_mode, .op_mac_negate, .op_done,
        .condition_code_flags, .first_acc, .second_acc);

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [55:0] seen, input logic [55:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk_state();
        chk("first_acc", first_acc, acc_m[0]);
        chk("second_acc", second_acc, acc_m[1]);
        chk("flags", condition_code_flags, f_m);
        chk("op_done", op_done, 1'b1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [23:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == dsd_pkg::REG_CCF) f_m = v[7:0];
        else if (a < 4'h5) xr[2'(a - 4'h1)] = v;
    endtask
    task automatic rd(input logic [3:0] a, input logic [23:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    task automatic load_acc(input logic d, input logic [55:0] v);
        wr(d ? 4'h8 : 4'h5, v[23:0]);
        wr(d ? 4'h9 : 4'h6, v[47:24]);
        wr(d ? 4'hA : 4'h7, {16'h0000, v[55:48]});
        acc_m[d] = v;
    endtask
    task automatic div_model(input logic d, input logic [23:0] s);
        logic [55:0] a;
        logic [55:0] sh;
        logic [31:0] up;
        a = acc_m[d];
        sh = {a[54:0], f_m[0]};
        up = (a[55] ^ s[23]) ? sh[55:24] + {{8{s[23]}}, s} : sh[55:24] - {{8{s[23]}}, s};
        acc_m[d] = {up, sh[23:0]};
        f_m[1] = a[55] ^ a[54];
        f_m[6] = f_m[6] | f_m[1];
        f_m[0] = ~up[31];
    endtask
    task automatic mac_model(input logic d, input logic [23:0] s1, input logic [23:0] s2,
                             input logic [1:0] m, input logic ng);
        logic [55:0] x, y, p, sh, r;
        // unsigned operands widen with zeros so they never count as negative
        x = (m == 2'b11) ? {32'h0, s1} : {{32{s1[23]}}, s1};
        y = (m == 2'b00) ? {{32{s2[23]}}, s2} : {32'h0, s2};
        p = x * y;
        sh = {{24{acc_m[d][55]}}, acc_m[d][55:24]};
        r = ng ? sh - p : sh + p;
        f_m[1] = (r[55] != sh[55]) && ((sh[55] == p[55]) != ng);
        f_m[6] = f_m[6] | f_m[1];
        f_m[5] = r[55:47] != 9'h000 && r[55:47] != 9'h1FF;
        f_m[4] = ~(r[47] ^ r[46]);
        f_m[3] = r[55];
        f_m[2] = r == 56'h0;
        acc_m[d] = r;
    endtask
    task automatic t_reset();
        chk_state_reset: begin
            chk("first_acc", first_acc, 56'h0);
            chk("flags", condition_code_flags, dsd_pkg::CCF_RESET);
            chk("second_acc", second_acc, 56'h0);
            chk("op_done", op_done, 1'b0);
            chk("reg_rdata", reg_rdata, 24'h000000);
        end
        rd(dsd_pkg::REG_CCF, 24'h000000);
        rd(dsd_pkg::REG_A_MID, 24'h000000);
        rd(4'hF, dsd_pkg::UNMAPPED_RD);
    endtask
    task automatic t_div(input logic d, input logic [1:0] js, input logic [55:0] dvd,
                         input logic [23:0] dvs, input logic [7:0] f0, input int n);
        wr(4'(js) + 4'h1, dvs);
        wr(dsd_pkg::REG_CCF, {16'h0000, f0});
        load_acc(d, dvd);
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            op_valid <= (i < n);
            op_is_div <= 1'b1;
            op_dest_sel <= d;
            divisor_select_field <= js;
            #1;
            if (i > 0) begin
                div_model(d, dvs);
                chk_state();
            end
        end
        rd(dsd_pkg::REG_CCF, {16'h0000, f_m});
    endtask
    task automatic t_mac(input logic d, input logic [3:0] q, input logic [1:0] m,
                         input logic ng, input logic wr_too);
        @(posedge clk);
        op_valid <= 1'b1;
        op_is_div <= 1'b0;
        op_dest_sel <= d;
        mac_source_pair_field <= q;
        op_mac_mode <= m;
        op_mac_negate <= ng;
        reg_wr <= wr_too;
        reg_addr <= dsd_pkg::REG_X_LO;
        reg_wdata <= ~xr[0];
        @(posedge clk);
        op_valid <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        mac_model(d, xr[q[3:2]], xr[q[1:0]], m, ng);
        chk_state();
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
    initial begin
        logic [7:0] tbl [6];
        tbl = '{8'h01, 8'h5A, 8'h3A, 8'hF6, 8'hAC, 8'h93};
        {rst_n, reg_wr, reg_rd, op_valid, op_is_div, op_dest_sel, op_mac_negate} = 7'h00;
        {reg_addr, mac_source_pair_field, divisor_select_field, op_mac_mode} = 12'h000;
        reg_wdata = 24'h000000;
        acc_m = '{56'h0, 56'h0};
        xr = '{24'h0, 24'h0, 24'h0, 24'h0};
        f_m = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_div(1'b0, 2'b00, 56'h00_200000_000000, 24'h400000, 8'h00,
              24);
        t_div(1'b1, 2'b11, 56'h00_123456_789ABC, 24'hA00000, 8'hBD,
              5);
        // shift moves bit 54 into the sign, so overflow must show
        t_div(1'b0, 2'b01, 56'h40_000000_000000, 24'h7FFFFF, 8'h00, 1);
        wr(dsd_pkg::REG_X_LO, 24'h800001);
        wr(dsd_pkg::REG_X_HI, 24'h7FFFFF);
        wr(dsd_pkg::REG_Y_LO, 24'hFFFFFF);
        wr(dsd_pkg::REG_Y_HI, 24'h000003);
        load_acc(1'b0, 56'hFF_876543_210FED);
        for (int i = 0; i < 6; i++) begin
            t_mac(tbl[i][7], tbl[i][3:0], tbl[i][5:4], tbl[i][6], 1'b0);
        end
        // a write beside an operation is dropped
        t_mac(1'b0, 4'b0100, 2'b00, 1'b0, 1'b1);
        rd(dsd_pkg::REG_X_LO, xr[0]);
        end_sim();
    end
endmodule
